// ---- rtl/tdc_cmd_consts.vh ----
// constants for the opcode command handler
`ifndef TDC_CMD_CONSTS_VH
`define TDC_CMD_CONSTS_VH

// apb byte addresses
`define ADDR_PORT 12'h000
`define ADDR_STATUS 12'h004

// status register fields
`define ST_CMD_LSB 0
`define ST_LEFT_LSB 8
`define ST_WAIT_WR_BIT 12
`define ST_WAIT_RD_BIT 13
`define ST_SHIFT_BIT 14

// opcode upper bytes
`define OP_RD_PATTERN 8'h47
`define OP_SET_OFFSET 8'h50
`define OP_RD_OFFSET 8'h51
`define OP_SET_ADJ 8'h52
`define OP_RD_ADJ 8'h53
`define OP_SET_RC 8'h54
`define OP_RD_RC 8'h55
`define OP_SAVE_RC 8'h56
`define OP_RD_ID 8'h60
`define OP_RD_FW 8'h61
`define OP_RESET_LOOPS 8'h62
`define OP_WR_SCAN 8'h70
`define OP_RD_SCAN 8'h71
`define OP_LOAD_SCAN 8'h72
`define OP_LOAD_DEFAULT 8'h73
`define OP_RD_ERRORS 8'h74
`define OP_RD_LOCK 8'h75
`define OP_RD_STATUS 8'h76
`define OP_LOAD_ONE 8'h77

// widths and sizes
`define COARSE_BITS 11
`define FINE_BITS 5
`define NUM_CHANNELS 128
`define NUM_CHIPS 4
`define ERR_BITS 11
`define CHIP_STATUS_BITS 62
`define SCAN_WORDS 41
`define SCAN_LAST_WORD 8'h28
`define SCAN_CFG_BITS 10'd646
`define SCAN_DEFAULT_WORD 16'h0000

// parameter word counts per opcode
`define WORDS_NONE 3'd0
`define WORDS_ONE 3'd1
`define WORDS_TWO 3'd2
`define WORDS_FOUR 3'd4

`endif

// ---- rtl/tdc_opcode_command_handler.v ----
// opcode port command handler with scan path shadow and serialiser
//
// How it works
// R1: chip pattern read gives two words, channels 0-15 then 16-31, one means enabled.
// R2: after an opcode needing words, wait and execute nothing else until all moved.
// R3: global offset set takes 11-bit coarse word then 5-bit fine word.
// R4: global offset read returns coarse word then fine word, same widths.
// R5: channel adjust set stores low 8 bits of one word, upper bits ignored.
// R6: channel adjust read returns that channel's 8-bit offset in low byte.
// R7: RC adjust set, read and save opcodes do nothing.
// R8: chip identity read returns one 16-bit identification word of chip n.
// R9: firmware read returns one word, release in low byte as major.minor digits.
// R10: reset opcode pulses loop reset of all chips, no words.
// R11: scan path is 646 config bits plus parity, held as 16-bit words.
// R12: parity bit is computed and inserted by hardware when programming.
// R13: scan word write only updates the shadow array.
// R14: scan word read returns the shadow array entry.
// R15: load opcode shifts the shadow array into all chips, no words.
// R16: reload-default opcode shifts default contents into all chips.
// R17: error read returns chip n's 11 error flags in the low bits.
// R18: lock read returns chip n's loop lock state in bit 0.
// R19: status read returns chip n's 62-bit status in four words.
// R20: single load shifts the shadow array into chip n only.
// R21: master delivers written words to the opcode port in order.
// R22: upper opcode byte is the command, low byte the index where used.
`timescale 1ns/1ps
`include "tdc_cmd_consts.vh"

module tdc_opcode_command_handler #(
   parameter [7:0] FW_REVISION = 8'h10
) (
   // clock, reset, enable
   input wire i_clock,
   input wire i_rst,
   input wire i_clk_en,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire o_pready,
   output reg [31:0] o_prdata,
   output wire o_pslverr,
   // chip readback, same clock domain
   input wire [`NUM_CHANNELS-1:0] i_chan_enable,
   input wire [`NUM_CHIPS*16-1:0] i_chip_id,
   input wire [`NUM_CHIPS*`ERR_BITS-1:0] i_chip_errors,
   input wire [`NUM_CHIPS-1:0] i_dll_lock,
   input wire [`NUM_CHIPS*`CHIP_STATUS_BITS-1:0] i_chip_status,
   // offsets to the chips
   output wire [`COARSE_BITS-1:0] o_coarse_offset,
   output wire [`FINE_BITS-1:0] o_fine_offset,
   output reg o_adj_strobe,
   output reg [6:0] o_adj_channel,
   output reg [7:0] o_adj_value,
   // loop reset
   output reg o_loop_reset,
   // setup scan path serial stream
   output reg o_scan_valid,
   output reg o_scan_data,
   output reg o_scan_last,
   output reg [`NUM_CHIPS-1:0] o_scan_chips
);

   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_WR = 4'b0010;
   localparam [3:0] ST_RD = 4'b0100;
   localparam [3:0] ST_SHIFT = 4'b1000;

   reg [3:0] state;
   reg [7:0] cmd;
   reg [7:0] idx;
   reg [2:0] words_left;
   reg [1:0] word_num;
   reg [`COARSE_BITS-1:0] coarse;
   reg [`FINE_BITS-1:0] fine;
   reg [7:0] adj [0:`NUM_CHANNELS-1];
   reg [15:0] shadow [0:`SCAN_WORDS-1];
   reg ack;
   reg err_q;
   reg [9:0] shift_cnt;
   reg parity;
   reg use_default;
   reg [`NUM_CHIPS-1:0] chip_mask;
   reg [15:0] rd_word;
   reg [15:0] src_word;
   reg scan_bit;
   reg [31:0] status_word;
   integer i;

   wire access = i_psel & i_penable & ~ack;
   wire hit_port = ({i_paddr[11:2], 2'b00} == `ADDR_PORT);
   wire hit_status = ({i_paddr[11:2], 2'b00} == `ADDR_STATUS);
   wire [1:0] chip = idx[1:0];
   wire idx_ok = (idx <= `SCAN_LAST_WORD);

   // opcode byte and per-chip readback slices
   wire [7:0] op_in = i_pwdata[15:8];
   wire [31:0] pattern_sel = i_chan_enable[{chip, 5'h00} +: 32];
   wire [`CHIP_STATUS_BITS-1:0] status_sel = i_chip_status[chip*`CHIP_STATUS_BITS +: `CHIP_STATUS_BITS];
   wire [`ERR_BITS-1:0] errors_sel = i_chip_errors[chip*`ERR_BITS +: `ERR_BITS];

   // number of parameter words for an opcode
   function [2:0] param_count;
      input [7:0] op;
      begin
         case (op)
            `OP_RD_PATTERN: param_count = `WORDS_TWO; // R1
            `OP_SET_OFFSET: param_count = `WORDS_TWO; // R3
            `OP_RD_OFFSET: param_count = `WORDS_TWO; // R4
            `OP_SET_ADJ: param_count = `WORDS_ONE; // R5
            `OP_RD_ADJ: param_count = `WORDS_ONE; // R6
            `OP_RD_ID: param_count = `WORDS_ONE; // R8
            `OP_RD_FW: param_count = `WORDS_ONE; // R9
            `OP_WR_SCAN: param_count = `WORDS_ONE; // R13
            `OP_RD_SCAN: param_count = `WORDS_ONE; // R14
            `OP_RD_ERRORS: param_count = `WORDS_ONE; // R17
            `OP_RD_LOCK: param_count = `WORDS_ONE; // R18
            `OP_RD_STATUS: param_count = `WORDS_FOUR; // R19
            `OP_RESET_LOOPS: param_count = `WORDS_NONE; // R10
            `OP_LOAD_SCAN: param_count = `WORDS_NONE; // R15
            `OP_LOAD_DEFAULT: param_count = `WORDS_NONE; // R16
            `OP_LOAD_ONE: param_count = `WORDS_NONE; // R20
            `OP_SET_RC: param_count = `WORDS_NONE; // R7
            `OP_RD_RC: param_count = `WORDS_NONE; // R7
            `OP_SAVE_RC: param_count = `WORDS_NONE; // R7
            default: param_count = `WORDS_NONE;
         endcase
      end
   endfunction

   // opcodes whose words flow from device to master
   function is_read;
      input [7:0] op;
      begin
         case (op)
            `OP_RD_PATTERN: is_read = 1'b1;
            `OP_RD_OFFSET: is_read = 1'b1;
            `OP_RD_ADJ: is_read = 1'b1;
            `OP_RD_ID: is_read = 1'b1;
            `OP_RD_FW: is_read = 1'b1;
            `OP_RD_SCAN: is_read = 1'b1;
            `OP_RD_ERRORS: is_read = 1'b1;
            `OP_RD_LOCK: is_read = 1'b1;
            `OP_RD_STATUS: is_read = 1'b1;
            `OP_SET_OFFSET: is_read = 1'b0;
            `OP_SET_ADJ: is_read = 1'b0;
            `OP_WR_SCAN: is_read = 1'b0;
            default: is_read = 1'b0;
         endcase
      end
   endfunction

   assign o_pready = ack;
   assign o_pslverr = ack & err_q;
   assign o_coarse_offset = coarse;
   assign o_fine_offset = fine;

   // word handed to the master on a read phase
   always @* begin
      rd_word = 16'h0000;
      case (cmd)
         `OP_RD_PATTERN: begin
            if (word_num[0])
               rd_word = pattern_sel[31:16]; // R1
            else
               rd_word = pattern_sel[15:0]; // R1
         end
         `OP_RD_OFFSET: begin
            if (word_num == 2'd0)
               rd_word = {5'h00, coarse}; // R4
            else
               rd_word = {11'h000, fine}; // R4
         end
         `OP_RD_ADJ: rd_word = {8'h00, adj[idx[6:0]]}; // R6
         `OP_RD_ID: rd_word = i_chip_id[{chip, 4'h0} +: 16]; // R8
         `OP_RD_FW: rd_word = {8'h00, FW_REVISION}; // R9
         `OP_RD_SCAN: begin
            if (idx_ok)
               rd_word = shadow[idx[5:0]]; // R14
         end
         `OP_RD_ERRORS: rd_word = {5'h00, errors_sel}; // R17
         `OP_RD_LOCK: rd_word = {15'h0000, i_dll_lock[chip]}; // R18
         `OP_RD_STATUS: begin
            // low 16 bits first, top word padded with zeros
            case (word_num)
               2'd0: rd_word = status_sel[15:0]; // R19
               2'd1: rd_word = status_sel[31:16]; // R19
               2'd2: rd_word = status_sel[47:32]; // R19
               default: rd_word = {2'b00, status_sel[61:48]}; // R19
            endcase
         end
         default: rd_word = 16'h0000;
      endcase
   end

   // status register image
   always @* begin
      status_word = 32'h00000000;
      status_word[`ST_CMD_LSB +: 8] = cmd;
      status_word[`ST_LEFT_LSB +: 3] = words_left;
      status_word[`ST_WAIT_WR_BIT] = (state == ST_WR);
      status_word[`ST_WAIT_RD_BIT] = (state == ST_RD);
      status_word[`ST_SHIFT_BIT] = (state == ST_SHIFT);
   end

   // next scan bit, word 0 bit 0 first
   always @* begin
      if (use_default)
         src_word = `SCAN_DEFAULT_WORD; // R16
      else
         src_word = shadow[shift_cnt[9:4]]; // R11
      scan_bit = src_word[shift_cnt[3:0]];
   end

   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
         cmd <= 8'h00;
         idx <= 8'h00;
         words_left <= 3'd0;
         word_num <= 2'd0;
         coarse <= {`COARSE_BITS{1'b0}};
         fine <= {`FINE_BITS{1'b0}};
         ack <= 1'b0;
         err_q <= 1'b0;
         o_prdata <= 32'h00000000;
         shift_cnt <= 10'd0;
         parity <= 1'b0;
         use_default <= 1'b0;
         chip_mask <= 4'h0;
         o_adj_strobe <= 1'b0;
         o_adj_channel <= 7'h00;
         o_adj_value <= 8'h00;
         o_loop_reset <= 1'b0;
         o_scan_valid <= 1'b0;
         o_scan_data <= 1'b0;
         o_scan_last <= 1'b0;
         o_scan_chips <= 4'h0;
         for (i = 0; i < `NUM_CHANNELS; i = i + 1) begin
            adj[i] <= 8'h00;
         end
         for (i = 0; i < `SCAN_WORDS; i = i + 1) begin
            shadow[i] <= 16'h0000;
         end
      end else if (i_clk_en) begin
         ack <= 1'b0;
         o_adj_strobe <= 1'b0;
         o_loop_reset <= 1'b0;
         o_scan_valid <= 1'b0;
         o_scan_last <= 1'b0;
         // bus answered one cycle after access; held off while shifting
         if (access && (state != ST_SHIFT)) begin
            ack <= 1'b1;
            err_q <= 1'b0;
            o_prdata <= 32'h00000000;
            if (hit_status) begin
               if (!i_pwrite)
                  o_prdata <= status_word;
            end else if (hit_port) begin
               case (state)
                  ST_IDLE: begin
                     if (i_pwrite) begin
                        cmd <= op_in; // R22
                        idx <= i_pwdata[7:0]; // R22
                        word_num <= 2'd0;
                        words_left <= param_count(op_in);
                        if (param_count(op_in) != `WORDS_NONE) begin
                           // R2
                           if (is_read(op_in))
                              state <= ST_RD;
                           else
                              state <= ST_WR;
                        end else begin
                           case (op_in)
                              `OP_RESET_LOOPS: o_loop_reset <= 1'b1; // R10
                              `OP_LOAD_SCAN: begin
                                 chip_mask <= 4'hf; // R15
                                 use_default <= 1'b0;
                                 shift_cnt <= 10'd0;
                                 parity <= 1'b0;
                                 state <= ST_SHIFT;
                              end
                              `OP_LOAD_DEFAULT: begin
                                 chip_mask <= 4'hf; // R16
                                 use_default <= 1'b1;
                                 shift_cnt <= 10'd0;
                                 parity <= 1'b0;
                                 state <= ST_SHIFT;
                              end
                              `OP_LOAD_ONE: begin
                                 chip_mask <= 4'h1 << i_pwdata[1:0]; // R20
                                 use_default <= 1'b0;
                                 shift_cnt <= 10'd0;
                                 parity <= 1'b0;
                                 state <= ST_SHIFT;
                              end
                              `OP_SET_RC, `OP_RD_RC, `OP_SAVE_RC: state <= ST_IDLE; // R7
                              default: state <= ST_IDLE;
                           endcase
                        end
                     end
                  end
                  ST_WR: begin
                     if (!i_pwrite) begin
                        err_q <= 1'b1; // R2
                     end else begin
                        // R21
                        case (cmd)
                           `OP_SET_OFFSET: begin
                              if (word_num == 2'd0)
                                 coarse <= i_pwdata[`COARSE_BITS-1:0]; // R3
                              else
                                 fine <= i_pwdata[`FINE_BITS-1:0]; // R3
                           end
                           `OP_SET_ADJ: begin
                              adj[idx[6:0]] <= i_pwdata[7:0]; // R5
                              o_adj_strobe <= 1'b1;
                              o_adj_channel <= idx[6:0];
                              o_adj_value <= i_pwdata[7:0];
                           end
                           `OP_WR_SCAN: begin
                              if (idx_ok)
                                 shadow[idx[5:0]] <= i_pwdata[15:0]; // R13
                           end
                           default: err_q <= 1'b0;
                        endcase
                        word_num <= word_num + 2'd1;
                        words_left <= words_left - 3'd1;
                        if (words_left == 3'd1)
                           state <= ST_IDLE; // R2
                     end
                  end
                  ST_RD: begin
                     if (i_pwrite) begin
                        err_q <= 1'b1; // R2
                     end else begin
                        o_prdata <= {16'h0000, rd_word};
                        word_num <= word_num + 2'd1;
                        words_left <= words_left - 3'd1;
                        if (words_left == 3'd1)
                           state <= ST_IDLE; // R2
                     end
                  end
                  default: state <= ST_IDLE;
               endcase
            end else begin
               err_q <= 1'b1;
            end
         end
         // serialise the setup scan path
         if (state == ST_SHIFT) begin
            o_scan_valid <= 1'b1;
            o_scan_chips <= chip_mask;
            if (shift_cnt < `SCAN_CFG_BITS) begin
               o_scan_data <= scan_bit; // R11
               parity <= parity ^ scan_bit; // R12
               shift_cnt <= shift_cnt + 10'd1;
            end else begin
               o_scan_data <= parity; // R12
               o_scan_last <= 1'b1;
               state <= ST_IDLE;
            end
         end
      end
   end

endmodule // tdc_opcode_command_handler

// ---- sim/tdc_cmd_checker.sv ----
// assertions on the opcode handler ports
`timescale 1ns/1ps
module tdc_cmd_checker (
   // clock and bus
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // pulses and scan stream
   input wire logic o_loop_reset,
   input wire logic o_adj_strobe,
   input wire logic o_scan_valid,
   input wire logic o_scan_last
);
   logic [10:0] run;
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst)
         run <= 11'h000;
      else if (i_clk_en)
         run <= o_scan_valid ? run + 11'h001 : 11'h000;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   ready_in_access_a: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
   ready_one_cycle_a: assert property (o_pready && i_clk_en |=> !o_pready) else $error("ready too long");
   ready_after_wait_a: assert property ($rose(i_penable) && i_psel && !o_scan_valid && i_clk_en |=> o_pready)
      else $error("no ready after one wait");
   error_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
   stall_in_shift_a: assert property (o_scan_valid && !o_scan_last |-> !o_pready) else $error("bus served mid shift");
   scan_length_a: assert property (o_scan_last |-> o_scan_valid && run == 11'd646) else $error("bad bit count");
   scan_stops_a: assert property (o_scan_last |=> !o_scan_valid) else $error("stream runs on");
   scan_burst_a: assert property ($rose(o_scan_valid) |-> o_scan_valid [*8]) else $error("stream gap");
   loop_pulse_a: assert property (o_loop_reset |=> !o_loop_reset) else $error("loop reset too long");
   adj_pulse_a: assert property (o_adj_strobe |=> !o_adj_strobe) else $error("adjust strobe too long");
   cover property (o_scan_last);
   cover property (o_loop_reset);
   cover property (o_pslverr);
endmodule // tdc_cmd_checker
bind tdc_opcode_command_handler tdc_cmd_checker u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
   .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_loop_reset(o_loop_reset),
   .o_adj_strobe(o_adj_strobe), .o_scan_valid(o_scan_valid), .o_scan_last(o_scan_last));

// ---- sim/tdc_host_model.sv ----
// apb master standing in for the bus host
`timescale 1ns/1ps
module tdc_host_model (
   // answer from the slave
   input wire logic i_clock,
   input wire logic i_pready,
   input wire logic [31:0] i_prdata,
   input wire logic i_pslverr,
   // request
   output logic o_psel = 1'b0,
   output logic o_penable = 1'b0,
   output logic o_pwrite = 1'b0,
   output logic [11:0] o_paddr = 12'h000,
   output logic [31:0] o_pwdata = 32'h00000000
);
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      int k = 0;
      @(posedge i_clock);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clock);
      o_penable <= 1'b1;
      @(posedge i_clock);
      while (i_pready !== 1'b1 && k < 2000) begin
         k++;
         @(posedge i_clock);
      end
      q = i_prdata;
      e = (k >= 2000) ? 1'b1 : i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule // tdc_host_model

// ---- sim/test_tdc_opcode_command_handler.sv ----
// self-checking bench for the opcode command handler
`timescale 1ns/1ps
module test_tdc_opcode_command_handler;
   typedef struct {logic [15:0] op; logic w; int n; logic [15:0] m; logic [63:0] d;} row_t;
   localparam logic [7:0] FW = 8'h10;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_clk_en = 1'b1;
   logic [127:0] i_chan_enable = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
   logic [63:0] i_chip_id = 64'h1a2b3c4d5e6f7081;
   logic [43:0] i_chip_errors = 44'h5a3c96e1b27;
   logic [3:0] i_dll_lock = 4'h4;
   logic [247:0] i_chip_status = {31{8'h6d}};
   wire i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_adj_strobe, o_loop_reset;
   wire o_scan_valid, o_scan_data, o_scan_last;
   wire [11:0] i_paddr;
   wire [31:0] i_pwdata, o_prdata;
   wire [10:0] o_coarse_offset;
   wire [4:0] o_fine_offset;
   wire [6:0] o_adj_channel;
   wire [7:0] o_adj_value;
   wire [3:0] o_scan_chips;
   int n_errors = 0, compares = 0, nb = 0, n_lr = 0, n_adj = 0, cyc = 0, j;
   logic b [0:1023];
   logic [3:0] seen;
   logic [31:0] q;
   logic e;
   row_t rows [16];

   tdc_opcode_command_handler #(.FW_REVISION(FW)) u_dut (.i_clock, .i_rst, .i_clk_en, .i_psel, .i_penable,
      .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_chan_enable, .i_chip_id, .i_chip_errors,
      .i_dll_lock, .i_chip_status, .o_coarse_offset, .o_fine_offset, .o_adj_strobe, .o_adj_channel, .o_adj_value,
      .o_loop_reset, .o_scan_valid, .o_scan_data, .o_scan_last, .o_scan_chips);
   tdc_host_model u_host (.i_clock, .i_pready(o_pready), .i_prdata(o_prdata), .i_pslverr(o_pslverr),
      .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata));

   always #12.5 i_clock = ~i_clock;

   // scan stream capture, pulse count, hang guard
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (o_scan_valid === 1'b1 && nb < 1024) begin
         b[nb] <= o_scan_data;
         nb <= nb + 1;
         seen <= o_scan_chips;
      end
      if (o_loop_reset === 1'b1)
         n_lr <= n_lr + 1;
      if (o_adj_strobe === 1'b1)
         n_adj <= n_adj + 1;
      if (cyc == 30000) begin
         n_errors++;
         give_verdict();
      end
   end

   task give_verdict;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task xf(input logic w, input logic [11:0] a, input logic [15:0] d);
      u_host.xfer(w, a, {16'h0000, d}, q, e);
   endtask

   // status read stalls until the shift is over
   task do_scan(input logic [15:0] op, input logic [3:0] ch, input logic v);
      nb = 0;
      xf(1'b1, 12'h000, op);
      xf(1'b0, 12'h004, 16'h0000);
      @(posedge i_clock);
      chk(nb, 647);
      chk(seen, ch);
      chk({b[0], b[639], b[640]}, {3{v}});
      chk(b[646], v);
   endtask

   initial begin
      logic [15:0] mk;
      rows[0] = '{16'h4702, 1'b0, 2, 16'hffff, {32'h0, i_chan_enable[80+:16], i_chan_enable[64+:16]}};
      rows[1] = '{16'h5000, 1'b1, 2, 16'hffff, {32'h0, 16'h00f3, 16'hfc05}};
      rows[2] = '{16'h5100, 1'b0, 2, 16'h07ff, {32'h0, 16'h0013, 16'h0405}};
      rows[3] = '{16'h527f, 1'b1, 1, 16'hffff, 64'hab5a};
      rows[4] = '{16'h537f, 1'b0, 1, 16'h00ff, 64'h005a};
      rows[5] = '{16'h6003, 1'b0, 1, 16'hffff, {48'h0, i_chip_id[48+:16]}};
      rows[6] = '{16'h6100, 1'b0, 1, 16'h00ff, {56'h0, FW}};
      rows[7] = '{16'h7000, 1'b1, 1, 16'hffff, 64'h0001};
      rows[8] = '{16'h7027, 1'b1, 1, 16'hffff, 64'h8000};
      rows[9] = '{16'h7028, 1'b1, 1, 16'hffff, 64'hc3a5};
      rows[10] = '{16'h7128, 1'b0, 1, 16'hffff, 64'hc3a5};
      rows[11] = '{16'h7029, 1'b1, 1, 16'hffff, 64'h1234};
      rows[12] = '{16'h7129, 1'b0, 1, 16'hffff, 64'h0000};
      rows[13] = '{16'h7401, 1'b0, 1, 16'h07ff, {53'h0, i_chip_errors[11+:11]}};
      rows[14] = '{16'h7502, 1'b0, 1, 16'h0001, {63'h0, i_dll_lock[2]}};
      rows[15] = '{16'h7603, 1'b0, 4, 16'hffff, {2'b00, i_chip_status[234+:14], i_chip_status[186+:48]}};
      repeat (10) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      chk({o_pready, o_scan_valid, o_coarse_offset}, 32'h0);
      foreach (rows[i]) begin
         xf(1'b1, 12'h000, rows[i].op);
         chk(e, 0);
         mk = rows[i].w ? 16'h0000 : rows[i].m;
         for (j = 0; j < rows[i].n; j++) begin
            xf(rows[i].w, 12'h000, rows[i].d[16*j+:16]);
            chk({e, q[15:0] & mk}, {1'b0, rows[i].d[16*j+:16] & mk});
         end
      end
      chk({o_coarse_offset, o_fine_offset, o_adj_channel, o_adj_value}, {11'h405, 5'h13, 7'h7f, 8'h5a});
      chk(n_adj, 1);
      xf(1'b1, 12'h000, 16'h5000);
      xf(1'b0, 12'h004, 16'h0000);
      chk(q[14:0], 15'h1250);
      xf(1'b0, 12'h000, 16'h0000);
      chk(e, 1);
      xf(1'b1, 12'h000, 16'h0001);
      xf(1'b1, 12'h000, 16'h0002);
      chk({o_coarse_offset, o_fine_offset}, {11'h001, 5'h02});
      xf(1'b0, 12'h008, 16'h0000);
      chk(e, 1);
      for (j = 0; j < 3; j++) begin
         xf(1'b1, 12'h000, {8'h54 + j[7:0], 8'h03});
         xf(1'b0, 12'h000, 16'h0000);
         chk(e, 0);
         chk(q, 0);
      end
      xf(1'b1, 12'h000, 16'h62a5);
      repeat (3) @(posedge i_clock);
      chk(n_lr, 1);
      do_scan(16'h7200, 4'hf, 1'b1);
      do_scan(16'h7702, 4'h4, 1'b1);
      do_scan(16'h7300, 4'hf, 1'b0);
      // reset in mid-command clears offsets and the pending wait
      xf(1'b1, 12'h000, 16'h5000);
      @(posedge i_clock);
      i_rst <= 1'b1;
      @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      chk({o_pready, o_scan_valid, o_coarse_offset, o_fine_offset}, 32'h0);
      xf(1'b0, 12'h004, 16'h0000);
      chk(q, 32'h0);
      give_verdict();
   end
endmodule // test_tdc_opcode_command_handler
